/* pkg/ebwc_pkg.sv */
/*
 * ebwc_pkg: constants, register map, states and carrier structs of the
 * external bus wait control block.
 * assumes: included before the design file; one 32-bit apb register space.
 */
package ebwc_pkg;

    // apb register byte offsets
    localparam logic [7:0] OFS_BUS_WIDTH   = 8'h00;
    localparam logic [7:0] OFS_ACCESS_ST   = 8'h04;
    localparam logic [7:0] OFS_DLY_ENABLE  = 8'h08;
    localparam logic [7:0] OFS_DLY_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_SEL_DIR     = 8'h10;
    localparam logic [7:0] OFS_STATUS      = 8'h14;

    // reset values
    localparam logic [7:0] RST_BUS_WIDTH   = 8'hff;
    localparam logic [7:0] RST_ACCESS_ST   = 8'hff;
    localparam logic [7:0] RST_DLY_ENABLE  = 8'hff;
    localparam logic [7:0] RST_DLY_CONTROL = 8'hf3;
    localparam logic [3:0] RST_SEL_DIR     = 4'h1;

    // delay_control field positions
    localparam int DLY_MODE_HI  = 3;
    localparam int DLY_MODE_LO  = 2;
    localparam int DLY_COUNT_HI = 1;
    localparam int DLY_COUNT_LO = 0;

    // delay mode select encodings
    localparam logic [1:0] MODE_PROG = 2'h0;
    localparam logic [1:0] MODE_NONE = 2'h1;
    localparam logic [1:0] MODE_PIN1 = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    localparam int NUM_AREAS = 8;
    localparam int NUM_SEL   = 4;
    localparam int ADDR_W    = 24;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TW,
        ST_T3
    } ebwc_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic              word;
        logic              rom;
        logic [15:0]       wdata;
    } ebwc_req_s;

    typedef struct packed {
        logic       narrow;
        logic       three_state;
        logic       ctl_enable;
        logic [1:0] mode;
        logic [1:0] count;
    } ebwc_cfg_s;

endpackage : ebwc_pkg

/* verilog/ebwc_ctrl.sv */
/*
 * ebwc_ctrl: external bus interface with area selects, data lane steering,
 * strobes for two- and three-state cycles and four delay modes.
 * assumes: apb master on mclk; one request at a time from the internal
 * master; pins hold_off_n and data_in come from outside and are synchronised.
 */
// How it works
// R1 - areas 0 to 3 each get an active-low area select, low during access
// R2 - after reset only area select 0 drives; others drive once direction bit set
// R3 - internal rom access drives area select 0 low, all strobes stay high; code lowers the select its address decodes, select 0 only for area 0
// R4 - area selects are plain address decodes usable as sram selects
// R5 - each area is 8-bit (upper lines only) or 16-bit (both halves)
// R6 - one read strobe for both halves; upper and lower write strobes per half
// R7 - 16-bit area: even byte upper, odd byte lower, word both halves
// R8 - unused read half ignored; unused write half carries arbitrary data
// R9 - lower write strobe stays high for every 8-bit area access
// R10 - only three-state cycles may take inserted delay states
// R11 - delay mode from three-state bit, controller enable and mode select
// R12 - three-state and enable bits per area; mode select shared by all
// R13 - pin mode 0: hold-off low at second state adds states until high
// R14 - pin mode 1: programmed count, then hold-off sampled in last one
// R15 - pin mode 1 with zero count acts as pin mode 0
// R16 - auto mode: hold-off low at second state adds exactly programmed count
// R17 - programmable mode: programmed count inserted regardless of hold-off
// R18 - two-bit count field is the number of inserted delay states
// R19 - reset loads 0xff, 0xff and 0xf3: three states, count three
// R20 - bus width bit 0 is 16-bit; three-state bit 1 is three-state
// R21 - delay states sit between second and third states, strobes held
`timescale 1ns/1ps
`default_nettype none
module ebwc_ctrl
    import ebwc_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // internal request port
    input  wire logic                  req_valid,
    input  wire ebwc_pkg::ebwc_req_s   req,
    output logic                       req_ready,
    output logic                       resp_valid,
    output logic [15:0]                resp_rdata,
    // external bus pins
    output logic [ebwc_pkg::ADDR_W-1:0] bus_addr,
    output logic                       address_strobe_n,
    output logic                       read_strobe_n,
    output logic                       upper_write_strobe_n,
    output logic                       lower_write_strobe_n,
    output logic [15:0]                data_out,
    output logic [15:0]                data_oe,
    input  wire logic [15:0]           data_in,
    input  wire logic                  hold_off_n,
    // area select pins
    output logic [ebwc_pkg::NUM_SEL-1:0] area_select_n,
    output logic [ebwc_pkg::NUM_SEL-1:0] area_select_oe
);
    import ebwc_pkg::*;

    ebwc_state_e          st_q;
    ebwc_req_s            cur_q;
    ebwc_cfg_s            cfg_q;
    ebwc_cfg_s            cfg_d;
    logic [7:0]           bus_width_q;
    logic [7:0]           access_state_q;
    logic [7:0]           dly_enable_q;
    logic [7:0]           dly_control_q;
    logic [NUM_SEL-1:0]   sel_dir_q;
    logic [1:0]           cnt_q;
    logic                 ext_q;
    logic                 hold_s1_q;
    logic                 hold_s2_q;
    logic [15:0]          din_s1_q;
    logic [15:0]          din_s2_q;
    logic [15:0]          dout_q;
    logic [15:0]          rdata_q;
    logic                 resp_q;
    logic                 fin_q;
    logic [2:0]           area;
    logic                 hold_low;
    logic                 last_state;
    logic                 wr_en;
    logic                 apb_hit;

    // synchronisers for pin inputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_s1_q <= 1'b1;
            hold_s2_q <= 1'b1;
            din_s1_q  <= 16'h0000;
            din_s2_q  <= 16'h0000;
        end else begin
            hold_s1_q <= hold_off_n;
            hold_s2_q <= hold_s1_q;
            din_s1_q  <= data_in;
            din_s2_q  <= din_s1_q;
        end
    end
    assign hold_low = ~hold_s2_q;

    // apb register file
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;
    always_comb begin
        apb_hit = 1'b1;
        prdata  = 32'h0000_0000;
        case (paddr)
            OFS_BUS_WIDTH:   prdata = {24'h00_0000, bus_width_q};
            OFS_ACCESS_ST:   prdata = {24'h00_0000, access_state_q};
            OFS_DLY_ENABLE:  prdata = {24'h00_0000, dly_enable_q};
            OFS_DLY_CONTROL: prdata = {24'h00_0000, dly_control_q};
            OFS_SEL_DIR:     prdata = {28'h000_0000, sel_dir_q};
            OFS_STATUS:      prdata = {26'h000_0000, cnt_q, ext_q, st_q};
            default:         apb_hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~apb_hit;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_width_q    <= RST_BUS_WIDTH;
            access_state_q <= RST_ACCESS_ST;   // [R19]
            dly_enable_q   <= RST_DLY_ENABLE;  // [R19]
            dly_control_q  <= RST_DLY_CONTROL; // [R19]
            sel_dir_q      <= RST_SEL_DIR;     // [R2]
        end else if (wr_en) begin
            case (paddr)
                OFS_BUS_WIDTH:   bus_width_q    <= pwdata[7:0];
                OFS_ACCESS_ST:   access_state_q <= pwdata[7:0];
                OFS_DLY_ENABLE:  dly_enable_q   <= pwdata[7:0];
                OFS_DLY_CONTROL: dly_control_q  <= pwdata[7:0];
                OFS_SEL_DIR:     sel_dir_q      <= pwdata[NUM_SEL-1:0];
                default:         ;
            endcase
        end
    end

    // per-area configuration, latched at cycle start so writes apply next cycle
    assign area = req.addr[ADDR_W-1 -: 3];
    always_comb begin
        cfg_d.narrow      = bus_width_q[area];     // [R5] [R20]
        cfg_d.three_state = access_state_q[area];  // [R20] [R12]
        cfg_d.ctl_enable  = dly_enable_q[area];    // [R12]
        cfg_d.mode        = {dly_control_q[DLY_MODE_HI], dly_control_q[DLY_MODE_LO]};
        cfg_d.count       = {dly_control_q[DLY_COUNT_HI], dly_control_q[DLY_COUNT_LO]};
    end

    assign req_ready  = (st_q == ST_IDLE);
    assign last_state = (st_q == ST_T3)
                        || (st_q == ST_T2 && (!cfg_q.three_state || cur_q.rom)); // [R3] [R10]

    // cycle sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q  <= ST_IDLE;
            cur_q <= '0;
            cfg_q <= '0;
            cnt_q <= 2'h0;
            ext_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        cur_q <= req;
                        cfg_q <= cfg_d;
                        st_q  <= ST_T1;
                    end
                end
                ST_T1: st_q <= ST_T2;
                ST_T2: begin
                    ext_q <= 1'b0;
                    cnt_q <= cfg_q.count;                     // [R18]
                    if (!cfg_q.three_state || cur_q.rom) begin
                        st_q <= ST_IDLE;                      // [R10]
                    end else if (!cfg_q.ctl_enable) begin
                        cnt_q <= 2'h1;
                        ext_q <= 1'b1;
                        st_q  <= hold_low ? ST_TW : ST_T3;    // [R11] [R13]
                    end else begin
                        case (cfg_q.mode)                     // [R11] [R12]
                            MODE_PROG: begin
                                st_q <= (cfg_q.count != 2'h0) ? ST_TW : ST_T3; // [R17]
                            end
                            MODE_PIN1: begin
                                ext_q <= 1'b1;                // [R14]
                                if (cfg_q.count == 2'h0) begin
                                    cnt_q <= 2'h1;            // [R15]
                                    st_q  <= hold_low ? ST_TW : ST_T3;
                                end else begin
                                    st_q <= ST_TW;
                                end
                            end
                            MODE_AUTO: begin
                                st_q <= (hold_low && cfg_q.count != 2'h0) ? ST_TW : ST_T3; // [R16]
                            end
                            default: st_q <= ST_T3;           // MODE_NONE
                        endcase
                    end
                end
                ST_TW: begin
                    if (cnt_q == 2'h1) begin
                        st_q <= (ext_q && hold_low) ? ST_TW : ST_T3; // [R13] [R14] [R21]
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                ST_T3:   st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // write data lanes and read capture
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout_q  <= 16'h0000;
            rdata_q <= 16'h0000;
            resp_q  <= 1'b0;
            fin_q   <= 1'b0;
        end else begin
            // synchronised read data lags two edges, so answer one edge after last state
            fin_q  <= (st_q != ST_IDLE) && last_state;
            resp_q <= fin_q;
            if (st_q == ST_IDLE && req_valid) begin
                if (req.word) begin
                    dout_q <= req.wdata;                            // [R7]
                end else begin
                    dout_q <= {req.wdata[7:0], req.wdata[7:0]};     // [R8]
                end
            end
            if (fin_q && !cur_q.write) begin
                if (cur_q.word && !cfg_q.narrow) begin
                    rdata_q <= din_s2_q;
                end else if (!cfg_q.narrow && cur_q.addr[0]) begin
                    rdata_q <= {8'h00, din_s2_q[7:0]};              // [R7] [R8]
                end else begin
                    rdata_q <= {8'h00, din_s2_q[15:8]};             // [R5] [R8]
                end
            end
        end
    end
    assign resp_valid = resp_q;
    assign resp_rdata = rdata_q;

    // external strobes and pins
    logic active;
    logic ext_cyc;
    logic wr_phase;
    assign active   = (st_q != ST_IDLE);
    assign ext_cyc  = active && !cur_q.rom;                        // [R3]
    assign wr_phase = ext_cyc && cur_q.write && (st_q != ST_T1);   // [R21]
    assign bus_addr             = cur_q.addr;
    assign address_strobe_n     = ~ext_cyc;
    assign read_strobe_n        = ~(ext_cyc && !cur_q.write);      // [R6]
    assign upper_write_strobe_n = ~(wr_phase && (cfg_q.narrow || cur_q.word
                                                || !cur_q.addr[0])); // [R6] [R7]
    assign lower_write_strobe_n = ~(wr_phase && !cfg_q.narrow
                                    && (cur_q.word || cur_q.addr[0])); // [R7] [R9]
    assign data_out             = dout_q;
    assign data_oe              = {16{ext_cyc && cur_q.write}};    // [R8]

    // area select decode, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SEL; gi++) begin : g_sel
            assign area_select_n[gi]  = ~(active && cur_q.addr[ADDR_W-1 -: 3] == gi); // [R1] [R4]
            assign area_select_oe[gi] = sel_dir_q[gi];                              // [R2]
        end
    endgenerate

    sequence s_prog_three;
        st_q == ST_TW [*3] ##1 st_q == ST_T3;
    endsequence

    property p_rom_quiet;
        @(posedge mclk) disable iff (rst)
        active && cur_q.rom |-> address_strobe_n && read_strobe_n
            && upper_write_strobe_n && lower_write_strobe_n && !area_select_n[0];
    endproperty
    a_rom_quiet: assert property (p_rom_quiet) // [R3]
        else $error("rom access drove a strobe or missed area select 0");

    property p_narrow_lower;
        @(posedge mclk) disable iff (rst)
        active && cfg_q.narrow |-> lower_write_strobe_n;
    endproperty
    a_narrow_lower: assert property (p_narrow_lower) // [R9]
        else $error("lower write strobe active in 8-bit area");

    property p_two_state;
        @(posedge mclk) disable iff (rst)
        st_q == ST_T1 && !cfg_q.three_state |=> st_q == ST_T2 ##1 st_q == ST_IDLE;
    endproperty
    a_two_state: assert property (p_two_state) // [R10]
        else $error("two-state cycle was extended");

    property p_prog_three;
        @(posedge mclk) disable iff (rst)
        st_q == ST_T2 && cfg_q.three_state && cfg_q.ctl_enable && !cur_q.rom
            && cfg_q.mode == MODE_PROG && cfg_q.count == 2'h3 |=> s_prog_three;
    endproperty
    a_prog_three: assert property (p_prog_three) // [R17]
        else $error("programmable mode did not insert three delay states");

    property p_auto_high;
        @(posedge mclk) disable iff (rst)
        st_q == ST_T2 && cfg_q.three_state && cfg_q.ctl_enable && !cur_q.rom
            && cfg_q.mode == MODE_AUTO && !hold_low |=> st_q == ST_T3;
    endproperty
    a_auto_high: assert property (p_auto_high) // [R16]
        else $error("auto mode inserted states with hold-off high");

    property p_pin0_extend;
        @(posedge mclk) disable iff (rst)
        st_q == ST_TW && ext_q && cnt_q == 2'h1 && hold_low |=> st_q == ST_TW;
    endproperty
    a_pin0_extend: assert property (p_pin0_extend) // [R13]
        else $error("delay state ended while hold-off low");

    property p_select_decode;
        @(posedge mclk) disable iff (rst)
        !area_select_n[0] |-> active && cur_q.addr[ADDR_W-1 -: 3] == 3'h0;
    endproperty
    a_select_decode: assert property (p_select_decode) // [R1]
        else $error("area select 0 low without area 0 access");

    property p_odd_lane;
        @(posedge mclk) disable iff (rst)
        wr_phase && !cfg_q.narrow && !cur_q.word && cur_q.addr[0]
            |-> upper_write_strobe_n && !lower_write_strobe_n;
    endproperty
    a_odd_lane: assert property (p_odd_lane) // [R7]
        else $error("odd byte write used wrong strobe");

    property p_reset_cfg;
        @(posedge mclk)
        $past(rst) && !rst |-> access_state_q == RST_ACCESS_ST
            && dly_control_q == RST_DLY_CONTROL && sel_dir_q == RST_SEL_DIR;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) // [R19]
        else $error("configuration not at reset values");

endmodule : ebwc_ctrl
`default_nettype wire

/* test/ebwc_mem.sv */
/*
 * ebwc_mem: word memory model standing on the external bus pins.
 * assumes: strobes, address and write data come from ebwc_ctrl on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ebwc_mem
    import ebwc_pkg::*;
(
    // clock
    input  wire logic                        mclk,
    // bus pins
    input  wire logic [ebwc_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic                        read_strobe_n,
    input  wire logic                        upper_write_strobe_n,
    input  wire logic                        lower_write_strobe_n,
    input  wire logic [15:0]                 data_out,
    output logic [15:0]                      data_in
);
    logic [15:0] mem [256];
    logic [15:0] last_q = 16'h0000;
    initial for (int i = 0; i < 256; i++) begin
        mem[i] = 16'h0000;
    end
    // each half written only while its own strobe is low
    always @(posedge mclk) begin
        if (!upper_write_strobe_n) mem[bus_addr[8:1]][15:8] <= data_out[15:8];
        if (!lower_write_strobe_n) mem[bus_addr[8:1]][7:0] <= data_out[7:0];
        last_q <= data_in;
    end
    // outside reads the lines show the inverse of the last value
    assign data_in = !read_strobe_n ? mem[bus_addr[8:1]] : ~last_q;
endmodule : ebwc_mem
`default_nettype wire

/* test/ebwc_ctrl_tb.sv */
/*
 * ebwc_ctrl_tb: apb and request-port tests of ebwc_ctrl with memory model.
 * assumes: zero-wait apb slave, request answered by a resp_valid pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module ebwc_ctrl_tb;
    import ebwc_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, req_ready, resp_valid;
    logic        req_valid = 1'b0, hold_off_n = 1'b1;
    ebwc_req_s   req = '0;
    logic [15:0] resp_rdata, data_out, data_in;
    logic [23:0] bus_addr;
    logic        as_n, rd_n, uw_n, lw_n, rd_seen, uw_seen, lw_seen;
    logic [3:0]  area_select_n, area_select_oe, cs_and;
    int          num_errors = 0, n_tests = 0, n_cyc, as_cnt;

    always #2 mclk = ~mclk;

    ebwc_ctrl u_ebwc_ctrl (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .bus_addr(bus_addr), .address_strobe_n(as_n), .read_strobe_n(rd_n),
        .upper_write_strobe_n(uw_n), .lower_write_strobe_n(lw_n), .data_out(data_out),
        .data_oe(), .data_in(data_in), .hold_off_n(hold_off_n),
        .area_select_n(area_select_n), .area_select_oe(area_select_oe));
    ebwc_mem u_ebwc_mem (.mclk(mclk), .bus_addr(bus_addr), .read_strobe_n(rd_n),
        .upper_write_strobe_n(uw_n), .lower_write_strobe_n(lw_n),
        .data_out(data_out), .data_in(data_in));

    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task test_done;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task op(input logic [23:0] a, input logic w, wd, rom, input logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, write: w, word: wd, rom: rom, wdata: d};
        req_valid <= 1'b1;
        do begin
            @(negedge mclk);
        end while (req_ready !== 1'b1);
        @(posedge mclk);
        req_valid <= 1'b0;
        {n_cyc, as_cnt, cs_and, rd_seen, uw_seen, lw_seen} = {32'd0, 32'd0, 4'hf, 3'b000};
        do begin
            @(negedge mclk);
            n_cyc++;
            as_cnt += (as_n === 1'b0);
            cs_and &= area_select_n;
            rd_seen |= (rd_n === 1'b0);
            uw_seen |= (uw_n === 1'b0);
            lw_seen |= (lw_n === 1'b0);
        end while (resp_valid !== 1'b1);
    endtask : op

    task mode_case(input logic [7:0] ast, en, ctl, input logic [23:0] a, input logic h,
                   input int exp);
        apb(1'b1, OFS_ACCESS_ST, {24'h0000_00, ast});
        hold_off_n <= h;
        apb(1'b1, OFS_DLY_ENABLE, {24'h0000_00, en});
        apb(1'b1, OFS_DLY_CONTROL, {24'h0000_00, ctl});
        op(a, 1'b0, 1'b0, 1'b0, 16'h0000);
        check(n_cyc, exp);
        check(as_cnt, exp - 2);
    endtask : mode_case

    task hold_case(input logic [7:0] en, ctl);
        apb(1'b1, OFS_DLY_ENABLE, {24'h0000_00, en});
        apb(1'b1, OFS_DLY_CONTROL, {24'h0000_00, ctl});
        hold_off_n <= 1'b0;
        fork
            op(24'h20_0003, 1'b0, 1'b0, 1'b0, 16'h0000);
            begin
                repeat (10) @(posedge mclk);
                hold_off_n <= 1'b1;
            end
        join
        check(n_cyc, 14);
    endtask : hold_case

    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, OFS_ACCESS_ST, 32'h0);
        check(rd, 32'h0000_00ff);
        apb(1'b0, OFS_DLY_ENABLE, 32'h0);
        check(rd, 32'h0000_00ff);
        apb(1'b0, OFS_DLY_CONTROL, 32'h0);
        check(rd, 32'h0000_00f3);
        apb(1'b0, OFS_BUS_WIDTH, 32'h0);
        check(rd, 32'h0000_00ff);
        check(area_select_oe, 4'b0001);
        apb(1'b0, 8'h18, 32'h0);
        check({err, rd}, 33'h1_0000_0000);
        $display("test registers done");
        hold_off_n <= 1'b0;
        op(24'h20_0003, 1'b1, 1'b0, 1'b0, 16'h0077);
        check(n_cyc, 8);
        check({uw_seen, lw_seen}, 2'b10);
        check(cs_and, 4'b1101);
        op(24'h20_0003, 1'b0, 1'b0, 1'b0, 16'h0000);
        check(resp_rdata, 16'h0077);
        apb(1'b1, OFS_SEL_DIR, 32'h0000_000f);
        @(negedge mclk);
        check(area_select_oe, 4'b1111);
        $display("test narrow area done");
        apb(1'b1, OFS_BUS_WIDTH, 32'h0000_00fe);
        apb(1'b1, OFS_ACCESS_ST, 32'h0000_00fe);
        op(24'h00_0010, 1'b1, 1'b1, 1'b0, 16'h1234);
        check(n_cyc, 4);
        check({uw_seen, lw_seen}, 2'b11);
        op(24'h00_0011, 1'b1, 1'b0, 1'b0, 16'h00ab);
        check({uw_seen, lw_seen}, 2'b01);
        op(24'h00_0010, 1'b1, 1'b0, 1'b0, 16'h00cd);
        check({uw_seen, lw_seen}, 2'b10);
        op(24'h00_0010, 1'b0, 1'b1, 1'b0, 16'h0000);
        check(resp_rdata, 16'hcdab);
        check({rd_seen, cs_and}, 5'b1_1110);
        op(24'h00_0011, 1'b0, 1'b0, 1'b0, 16'h0000);
        check(resp_rdata, 16'h00ab);
        op(24'h00_0020, 1'b0, 1'b0, 1'b1, 16'h0000);
        check({as_cnt[3:0], rd_seen, uw_seen, lw_seen, cs_and}, 11'h00e);
        $display("test lanes done");
        mode_case(8'hff, 8'hff, 8'h01, 24'h20_0003, 1'b0, 6);
        mode_case(8'hff, 8'hff, 8'h05, 24'h20_0003, 1'b0, 5);
        mode_case(8'hff, 8'hff, 8'h0e, 24'h20_0003, 1'b1, 5);
        mode_case(8'hff, 8'hff, 8'h0e, 24'h20_0003, 1'b0, 7);
        mode_case(8'hff, 8'hff, 8'h09, 24'h20_0003, 1'b1, 6);
        mode_case(8'hff, 8'hff, 8'h08, 24'h20_0003, 1'b1, 5);
        mode_case(8'hff, 8'hfd, 8'h01, 24'h20_0003, 1'b1, 5);
        mode_case(8'hff, 8'hfd, 8'h01, 24'h40_0003, 1'b1, 6);
        mode_case(8'hfd, 8'hff, 8'h01, 24'h20_0003, 1'b0, 4);
        mode_case(8'hff, 8'hff, 8'h01, 24'h20_0003, 1'b1, 6);
        hold_case(8'hfd, 8'h01);
        hold_case(8'hff, 8'h09);
        $display("test delay modes done");
        test_done;
    end
endmodule : ebwc_ctrl_tb
`default_nettype wire
